// ---- hdl/plk_pin_if.sv ----
// Carrier between the top and one status or general-purpose pin selector.
`timescale 1ns/1ps
interface plk_pin_if;
    logic gpMode;
    logic gpOut;
    logic status;
    logic pin;
    modport ctrl(output gpMode, output gpOut, output status, input pin);
    modport mux(input gpMode, input gpOut, input status, output pin);
endinterface : plk_pin_if

// ---- hdl/plk_pin_mux.sv ----
// Selects status mirroring or a software output bit for one status pin.
`timescale 1ns/1ps
module plk_pin_mux (
    input wire logic clk,
    input wire logic rstn,
    plk_pin_if.mux pinIf
);
    logic pin_q;

    // Registered pin: status flag by default, software bit in output mode.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pinIf.gpMode ? pinIf.gpOut : pinIf.status;
        end
    end

    assign pinIf.pin = pin_q;

    property p_mux_status;
        @(posedge clk) disable iff (!rstn)
        !pinIf.gpMode |=> pin_q == $past(pinIf.status);
    endproperty
    a_mux_status: assert property (p_mux_status) else $error("Pin does not mirror status.");

    property p_mux_gp;
        @(posedge clk) disable iff (!rstn)
        pinIf.gpMode |=> pin_q == $past(pinIf.gpOut);
    endproperty
    a_mux_gp: assert property (p_mux_gp) else $error("Pin does not follow output bit.");
endmodule : plk_pin_mux

// ---- hdl/plk_pkg.sv ----
// Shared constants and types for the PHY-link pin, cycle clock and status pin block.
package plk_pkg;
    // Host clock rate and period.
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    // Cycle clock rate and the host clock count of one cycle period.
    localparam int CYCLE_HZ = 8000;
    localparam int CYCLE_CLKS = CLK_HZ / CYCLE_HZ;
    localparam int CYC_W = 12;
    localparam logic [CYC_W-1:0] CYCLE_LAST = CYC_W'(CYCLE_CLKS - 1);
    localparam logic [CYC_W-1:0] CYCLE_OUT_HIGH = CYC_W'(CYCLE_CLKS / 2);
    // Shortest external cycle pulse, and the host clocks it spans (rounded up).
    localparam int EXT_PULSE_MIN_NS = 80;
    localparam int EXT_PULSE_CLKS = (EXT_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Power indicator divides the host clock by this ratio.
    localparam int POWER_DIV = 32;
    localparam logic [3:0] POWER_HALF_LAST = 4'((POWER_DIV / 2) - 1);
    // Least reset low time in host clocks.
    localparam int RESET_MIN_CLKS = 2;
    // Control bus codes, read the same way by both ends.
    typedef enum logic [1:0] {
        PLK_CTL_IDLE = 2'h0,
        PLK_CTL_STATUS = 2'h1,
        PLK_CTL_RECEIVE = 2'h2,
        PLK_CTL_GRANT = 2'h3
    } plk_ctl_t;
    // Receive speed codes.
    typedef enum logic [1:0] {
        PLK_SPD_100 = 2'h0,
        PLK_SPD_200 = 2'h1,
        PLK_SPD_400 = 2'h2
    } plk_speed_t;
    // Link request serial word: type codes and lengths in bits.
    localparam int REQ_W = 17;
    localparam logic [2:0] REQ_READ = 3'h4;
    localparam logic [2:0] REQ_WRITE = 3'h5;
    localparam logic [4:0] REQ_LEN_BUS = 5'h08;
    localparam logic [4:0] REQ_LEN_READ = 5'h09;
    localparam logic [4:0] REQ_LEN_WRITE = 5'h11;
    // Cycle-start recognition in a received packet.
    localparam logic [3:0] TCODE_CYCLE_START = 4'h8;
    localparam logic [2:0] TCODE_BYTE = 3'h3;
    localparam logic [2:0] RX_BYTE_MAX = 3'h4;
    localparam logic [3:0] RX_BYTE_BITS = 4'h8;
    // Request shifter states.
    typedef enum logic {LQ_IDLE, LQ_SHIFT} plk_lreq_state_t;
endpackage : plk_pkg

// ---- hdl/plk_sync.sv ----
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
module plk_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule : plk_sync

// ---- hdl/plk_top.sv ----
// PHY-link pins, power indicator, cycle clock and status pins of the link controller.
`timescale 1ns/1ps
module plk_top
    import plk_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic [1:0] ctlIn,
    output logic [1:0] ctlOut,
    output logic ctlOe,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic linkRequest,
    output logic halfRateClk,
    output logic linkPowerIndicator,
    input wire logic linkPowerUp,
    input wire logic [1:0] rxSpeed,
    input wire logic reqValid,
    input wire logic [2:0] reqType,
    input wire logic [2:0] reqSpeed,
    input wire logic [3:0] reqAddr,
    input wire logic [7:0] reqData,
    output logic reqReady,
    input wire logic extCycleClockIn,
    output logic cycleClockOut,
    input wire logic cycleTimerEnable,
    input wire logic cycleMaster,
    input wire logic cycleSourceExt,
    input wire logic rxFifoEmptyFlag,
    input wire logic cycleDoneEvent,
    input wire logic cycleDoneClear,
    input wire logic cycleStartClear,
    output logic cycleDoneFlag,
    output logic cycleStartFlag,
    input wire logic pinCfgWrite,
    input wire logic [2:0] pinGpModeIn,
    input wire logic [2:0] pinGpOutIn,
    output logic rxFifoEmptyPinOrGpout0,
    output logic cycleDonePinOrGpout1,
    output logic cycleStartPinOrGpout2
);
    logic rstn;
    logic linkRstn;
    logic extSync;
    logic extPrev_q;
    logic extFall;
    logic [3:0] powerCnt_q;
    logic powerInd_q;
    logic reqToggle_q;
    logic reqAckSync;
    logic [REQ_W-1:0] reqWord_q;
    logic [REQ_W-1:0] reqWord_d;
    logic [4:0] reqLen_q;
    logic [4:0] reqLen_d;
    logic rxCsSync;
    logic rxCsPrev_q;
    logic rxCsEvent;
    logic cycleTick;
    logic [CYC_W-1:0] cycleCnt_q;
    logic cycle_clock_out_q;
    logic cycleDone_q;
    logic cycleStart_q;
    logic [2:0] gpMode_q;
    logic [2:0] gpOut_q;
    logic [2:0] statusVec;
    logic [2:0] pinVec;
    logic halfClk_q;
    logic [1:0] speedL;
    logic reqSyncL;
    logic reqSeen_q;
    plk_lreq_state_t lqState_q;
    logic [REQ_W-1:0] lqShift_q;
    logic [4:0] lqLeft_q;
    logic lreq_q;
    logic ctlOe_q;
    logic [7:0] rxByte_q;
    logic [7:0] rxNext;
    logic [3:0] rxStep;
    logic [3:0] bitCnt_q;
    logic [3:0] bitSum;
    logic [2:0] byteIdx_q;
    logic rxCsToggle_q;

    // Reset is asserted at once and released through two flops in each domain.
    plk_sync #(.WIDTH(1)) uRstClk (.clk(clk), .rstn(resetn), .din(1'b1), .dout(rstn));
    plk_sync #(.WIDTH(1)) uRstLink (.clk(sclk), .rstn(resetn), .din(1'b1), .dout(linkRstn));

    // Crossings between the host clock and the PHY clock, and the external cycle input into the host clock.
    plk_sync #(.WIDTH(1)) uExt (.clk(clk), .rstn(rstn), .din(extCycleClockIn), .dout(extSync));
    plk_sync #(.WIDTH(1)) uAck (.clk(clk), .rstn(rstn), .din(reqSeen_q), .dout(reqAckSync));
    plk_sync #(.WIDTH(1)) uCs (.clk(clk), .rstn(rstn), .din(rxCsToggle_q), .dout(rxCsSync));
    plk_sync #(.WIDTH(1)) uReq (.clk(sclk), .rstn(linkRstn), .din(reqToggle_q), .dout(reqSyncL));
    plk_sync #(.WIDTH(2)) uSpd (.clk(sclk), .rstn(linkRstn), .din(rxSpeed), .dout(speedL));

    // Power indicator toggles every sixteen host clocks while powered up.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            powerCnt_q <= 4'h0;
            powerInd_q <= 1'b0;
        end else if (!linkPowerUp) begin
            powerCnt_q <= 4'h0;
            powerInd_q <= 1'b0;
        end else begin
            powerCnt_q <= powerCnt_q + 4'h1;
            if (powerCnt_q == POWER_HALF_LAST) begin
                powerInd_q <= ~powerInd_q;
            end
        end
    end

    // Serial request word, start bit first, stop bit last.
    always_comb begin
        reqWord_d = '0;
        reqLen_d = REQ_LEN_BUS;
        case (reqType)
            REQ_READ: begin
                reqWord_d = {1'b1, reqType, reqAddr, 1'b0, 8'h00};
                reqLen_d = REQ_LEN_READ;
            end
            REQ_WRITE: begin
                reqWord_d = {1'b1, reqType, reqAddr, reqData, 1'b0};
                reqLen_d = REQ_LEN_WRITE;
            end
            default: begin
                reqWord_d = {1'b1, reqType, reqSpeed, 1'b0, 9'h000};
                reqLen_d = REQ_LEN_BUS;
            end
        endcase
    end

    // Host side of the request handshake; the word stays still until acknowledged.
    assign reqReady = (reqToggle_q == reqAckSync);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reqToggle_q <= 1'b0;
            reqWord_q <= '0;
            reqLen_q <= REQ_LEN_BUS;
        end else if (reqValid && reqReady) begin
            reqToggle_q <= ~reqToggle_q;
            reqWord_q <= reqWord_d;
            reqLen_q <= reqLen_d;
        end
    end

    // Edge detectors on the synchronised external cycle input and cycle-start event.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extPrev_q <= 1'b0;
            rxCsPrev_q <= 1'b0;
        end else begin
            extPrev_q <= extSync;
            rxCsPrev_q <= rxCsSync;
        end
    end
    assign extFall = extPrev_q & ~extSync;
    assign rxCsEvent = rxCsPrev_q ^ rxCsSync;

    // A cycle begins on the selected source: external input, own timer or the bus.
    always_comb begin
        if (!cycleTimerEnable) begin
            cycleTick = 1'b0;
        end else if (cycleSourceExt) begin
            cycleTick = extFall;
        end else if (cycleMaster) begin
            cycleTick = (cycleCnt_q == CYCLE_LAST);
        end else begin
            cycleTick = rxCsEvent;
        end
    end

    // Cycle counter restarts on each cycle and holds at its end if no cycle begins.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cycleCnt_q <= CYCLE_LAST;
            cycle_clock_out_q <= 1'b0;
        end else if (!cycleTimerEnable) begin
            cycleCnt_q <= CYCLE_LAST;
            cycle_clock_out_q <= 1'b0;
        end else if (cycleTick) begin
            cycleCnt_q <= '0;
            cycle_clock_out_q <= 1'b1;
        end else begin
            if (cycleCnt_q != CYCLE_LAST) begin
                cycleCnt_q <= cycleCnt_q + CYC_W'(1);
            end
            cycle_clock_out_q <= (cycleCnt_q < CYCLE_OUT_HIGH - CYC_W'(1));
        end
    end

    // Sticky flags; an event in the clearing cycle keeps the flag set.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cycleDone_q <= 1'b0;
            cycleStart_q <= 1'b0;
        end else begin
            cycleDone_q <= cycleDoneEvent | (cycleDone_q & ~cycleDoneClear);
            cycleStart_q <= cycleTick | (cycleStart_q & ~cycleStartClear);
        end
    end

    // Pin configuration: all pins start in status mode.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gpMode_q <= 3'h0;
            gpOut_q <= 3'h0;
        end else if (pinCfgWrite) begin
            gpMode_q <= pinGpModeIn;
            gpOut_q <= pinGpOutIn;
        end
    end

    // One selector per status pin.
    assign statusVec = {cycleStart_q, cycleDone_q, rxFifoEmptyFlag};
    plk_pin_if pinIf[3] ();
    for (genvar i = 0; i < 3; i++) begin : gPin
        assign pinIf[i].gpMode = gpMode_q[i];
        assign pinIf[i].gpOut = gpOut_q[i];
        assign pinIf[i].status = statusVec[i];
        assign pinVec[i] = pinIf[i].pin;
        plk_pin_mux uMux (.clk(clk), .rstn(rstn), .pinIf(pinIf[i]));
    end

    // Half-rate clock from the PHY clock.
    always_ff @(posedge sclk or negedge linkRstn) begin
        if (!linkRstn) begin
            halfClk_q <= 1'b0;
        end else begin
            halfClk_q <= ~halfClk_q;
        end
    end

    // Request shifter sends the word serially, then acknowledges the host.
    always_ff @(posedge sclk or negedge linkRstn) begin
        if (!linkRstn) begin
            lqState_q <= LQ_IDLE;
            lqShift_q <= '0;
            lqLeft_q <= 5'h00;
            reqSeen_q <= 1'b0;
            lreq_q <= 1'b0;
        end else begin
            unique case (lqState_q)
                LQ_IDLE: begin
                    lreq_q <= 1'b0;
                    if (reqSyncL != reqSeen_q) begin
                        lreq_q <= reqWord_q[REQ_W-1];
                        lqShift_q <= {reqWord_q[REQ_W-2:0], 1'b0};
                        lqLeft_q <= reqLen_q - 5'h01;
                        lqState_q <= LQ_SHIFT;
                    end
                end
                LQ_SHIFT: begin
                    if (lqLeft_q == 5'h00) begin
                        lreq_q <= 1'b0;
                        reqSeen_q <= reqSyncL;
                        lqState_q <= LQ_IDLE;
                    end else begin
                        lreq_q <= lqShift_q[REQ_W-1];
                        lqShift_q <= {lqShift_q[REQ_W-2:0], 1'b0};
                        lqLeft_q <= lqLeft_q - 5'h01;
                    end
                end
            endcase
        end
    end

    // After a grant the link drives idle for one cycle to hand the bus back.
    always_ff @(posedge sclk or negedge linkRstn) begin
        if (!linkRstn) begin
            ctlOe_q <= 1'b0;
        end else begin
            ctlOe_q <= (ctlIn == PLK_CTL_GRANT) && !ctlOe_q;
        end
    end

    // Lines used per cycle depend on the receive speed.
    always_comb begin
        unique case (speedL)
            PLK_SPD_100: begin
                rxNext = {rxByte_q[5:0], dataIn[1:0]};
                rxStep = 4'h2;
            end
            PLK_SPD_200: begin
                rxNext = {rxByte_q[3:0], dataIn[3:0]};
                rxStep = 4'h4;
            end
            default: begin
                rxNext = dataIn;
                rxStep = 4'h8;
            end
        endcase
    end
    assign bitSum = bitCnt_q + rxStep;

    // Byte assembly; the type code byte flags a received cycle-start message.
    always_ff @(posedge sclk or negedge linkRstn) begin
        if (!linkRstn) begin
            rxByte_q <= 8'h00;
            bitCnt_q <= 4'h0;
            byteIdx_q <= 3'h0;
            rxCsToggle_q <= 1'b0;
        end else if (ctlIn != PLK_CTL_RECEIVE) begin
            bitCnt_q <= 4'h0;
            byteIdx_q <= 3'h0;
        end else begin
            rxByte_q <= rxNext;
            bitCnt_q <= (bitSum == RX_BYTE_BITS) ? 4'h0 : bitSum;
            if (bitSum == RX_BYTE_BITS && byteIdx_q != RX_BYTE_MAX) begin
                byteIdx_q <= byteIdx_q + 3'h1;
                if (byteIdx_q == TCODE_BYTE && rxNext[7:4] == TCODE_CYCLE_START) begin
                    rxCsToggle_q <= ~rxCsToggle_q;
                end
            end
        end
    end

    assign ctlOut = PLK_CTL_IDLE;
    assign ctlOe = ctlOe_q;
    assign dataOut = 8'h00;
    assign dataOe = ctlOe_q;
    assign linkRequest = lreq_q;
    assign halfRateClk = halfClk_q;
    assign linkPowerIndicator = powerInd_q;
    assign cycleClockOut = cycle_clock_out_q;
    assign cycleDoneFlag = cycleDone_q;
    assign cycleStartFlag = cycleStart_q;
    assign rxFifoEmptyPinOrGpout0 = pinVec[0];
    assign cycleDonePinOrGpout1 = pinVec[1];
    assign cycleStartPinOrGpout2 = pinVec[2];

    property p_power_period;
        @(posedge clk) disable iff (!rstn || !linkPowerUp)
        $rose(powerInd_q) |-> powerInd_q[*8] ##8 powerInd_q ##1 !powerInd_q;
    endproperty
    a_power_period: assert property (p_power_period) else $error("Bad power period.");

    property p_power_off;
        @(posedge clk) disable iff (!rstn)
        !linkPowerUp |=> !powerInd_q && powerCnt_q == 4'h0;
    endproperty
    a_power_off: assert property (p_power_off) else $error("Indicator active unpowered.");

    property p_ext_tick;
        @(posedge clk) disable iff (!rstn)
        cycleTimerEnable && cycleSourceExt && extFall |=> cycleStart_q && cycleCnt_q == '0;
    endproperty
    a_ext_tick: assert property (p_ext_tick) else $error("External pulse missed.");

    property p_master_count;
        @(posedge clk) disable iff (!rstn)
        cycleTimerEnable && cycleMaster && !cycleSourceExt && cycleCnt_q != CYCLE_LAST
            |=> cycleCnt_q == $past(cycleCnt_q) + CYC_W'(1);
    endproperty
    a_master_count: assert property (p_master_count) else $error("Cycle count slipped.");

    property p_cycle_out;
        @(posedge clk) disable iff (!rstn || !cycleTimerEnable)
        cycleTick |=> cycle_clock_out_q[*8];
    endproperty
    a_cycle_out: assert property (p_cycle_out) else $error("Cycle output not high.");

    property p_start_flag;
        @(posedge clk) disable iff (!rstn)
        cycleTick || (cycleStart_q && !cycleStartClear) |=> cycleStart_q ##1 cycleStartPinOrGpout2
            || gpMode_q[2];
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("Cycle start lost.");

    property p_done_flag;
        @(posedge clk) disable iff (!rstn)
        cycleDoneEvent && !gpMode_q[1] |=> cycleDone_q ##1 (cycleDonePinOrGpout1 || gpMode_q[1]);
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("Cycle done lost.");

    property p_mode_hold;
        @(posedge clk) disable iff (!rstn)
        !pinCfgWrite |=> gpMode_q == $past(gpMode_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("Pin mode changed alone.");

    property p_req_busy;
        @(posedge clk) disable iff (!rstn)
        reqValid && reqReady |=> !reqReady [*2];
    endproperty
    a_req_busy: assert property (p_req_busy) else $error("Request not held.");

    property p_lreq_start;
        @(posedge sclk) disable iff (!linkRstn)
        lqState_q == LQ_IDLE && reqSyncL != reqSeen_q |=> linkRequest ##1 lqState_q == LQ_SHIFT;
    endproperty
    a_lreq_start: assert property (p_lreq_start) else $error("No start bit.");

    property p_half_clk;
        @(posedge sclk) disable iff (!linkRstn)
        halfClk_q |=> !halfRateClk ##1 halfRateClk;
    endproperty
    a_half_clk: assert property (p_half_clk) else $error("Half clock wrong.");

    property p_grant;
        @(posedge sclk) disable iff (!linkRstn)
        ctlIn == PLK_CTL_GRANT && !ctlOe_q |=> ctlOe && ctlOut == PLK_CTL_IDLE ##1 !ctlOe;
    endproperty
    a_grant: assert property (p_grant) else $error("Grant release wrong.");

    property p_rx_width;
        @(posedge sclk) disable iff (!linkRstn)
        ctlIn == PLK_CTL_RECEIVE && speedL == PLK_SPD_100
            |=> rxByte_q == {$past(rxByte_q[5:0]), $past(dataIn[1:0])};
    endproperty
    a_rx_width: assert property (p_rx_width) else $error("Wrong lines sampled.");

    c_ext_cycle: cover property (@(posedge clk) disable iff (!rstn) cycleSourceExt && cycleTick);
    c_master_cycle: cover property (@(posedge clk) disable iff (!rstn) cycleMaster && cycleTick);
    c_rx_start: cover property (@(posedge clk) disable iff (!rstn) rxCsEvent);
    c_lreq_done: cover property (@(posedge sclk) disable iff (!linkRstn)
        lqState_q == LQ_SHIFT && lqLeft_q == 5'h00);
endmodule : plk_top

// ---- tb/plk_phy_model.sv ----
// Behavioural PHY: drives the control and data lines and captures link requests.
`timescale 1ns/1ps
module plk_phy_model (
    input wire logic sclk,
    output logic [1:0] ctl,
    output logic [7:0] data,
    input wire logic lreq
);
    logic [16:0] reqWord = '0;
    logic busy = 1'b0;
    logic rx = 1'b0;
    int bitCnt = 0;
    initial begin
        ctl = 2'h0;
        data = 8'h5a;
    end
    // Idle data lines show a pattern that changes every cycle, never a stale value.
    always @(posedge sclk) begin
        if (!rx) data <= ~data;
    end
    // Captures one serial request word, most significant bit first.
    always @(posedge sclk) begin
        if (busy || lreq) begin
            reqWord <= {reqWord[15:0], lreq};
            busy <= (bitCnt < 16);
            bitCnt <= (bitCnt < 16) ? bitCnt + 1 : 0;
        end
    end
    // Sends four bytes on the w low lines; byte 3 carries the cycle-start code.
    task automatic sendPkt(input int w, input logic [23:0] hdr);
        logic [31:0] pkt;
        pkt = {hdr, 4'h8, hdr[3:0]};
        // Raised ahead of the edge so the idle pattern cannot overwrite the first chunk.
        rx = 1'b1;
        @(posedge sclk);
        ctl <= 2'h2;
        for (int i = 32 - w; i >= 0; i -= w) begin
            data <= 8'(pkt >> i) & 8'((1 << w) - 1);
            @(posedge sclk);
        end
        ctl <= 2'h0;
        rx <= 1'b0;
    endtask : sendPkt
    // Shows a grant for one cycle and returns at the edge where the link samples it.
    task automatic grant;
        @(posedge sclk);
        ctl <= 2'h3;
        @(posedge sclk);
        ctl <= 2'h0;
    endtask : grant
endmodule : plk_phy_model

// ---- tb/plk_top_tb_top.sv ----
// Testbench: drives the link block beside the PHY model and checks its pins.
`timescale 1ns/1ps
module plk_top_tb_top
    import plk_pkg::*;
;
    logic clk, resetn, sclk, ctlOe, dataOe, linkRequest, halfRateClk, linkPowerIndicator;
    logic linkPowerUp, reqValid, reqReady, extCycleClockIn, cycleClockOut, cycleTimerEnable;
    logic cycleMaster, cycleSourceExt, rxFifoEmptyFlag, cycleDoneEvent, cycleDoneClear;
    logic cycleStartClear, cycleDoneFlag, cycleStartFlag, pinCfgWrite, pin0, pin1, pin2;
    logic [1:0] ctlIn, ctlOut, rxSpeed;
    logic [7:0] dataIn, dataOut, reqData;
    logic [2:0] reqType, reqSpeed, pinGpModeIn, pinGpOutIn;
    logic [3:0] reqAddr;
    logic [16:0] expWord;
    logic hb;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    plk_top plk_top_inst (.clk(clk), .resetn(resetn), .sclk(sclk), .ctlIn(ctlIn),
        .ctlOut(ctlOut), .ctlOe(ctlOe), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
        .linkRequest(linkRequest), .halfRateClk(halfRateClk), .linkPowerUp(linkPowerUp),
        .linkPowerIndicator(linkPowerIndicator), .rxSpeed(rxSpeed), .reqValid(reqValid),
        .reqType(reqType), .reqSpeed(reqSpeed), .reqAddr(reqAddr), .reqData(reqData),
        .reqReady(reqReady), .extCycleClockIn(extCycleClockIn), .cycleClockOut(cycleClockOut),
        .cycleTimerEnable(cycleTimerEnable), .cycleMaster(cycleMaster),
        .cycleSourceExt(cycleSourceExt), .rxFifoEmptyFlag(rxFifoEmptyFlag),
        .cycleDoneEvent(cycleDoneEvent), .cycleDoneClear(cycleDoneClear),
        .cycleStartClear(cycleStartClear), .cycleDoneFlag(cycleDoneFlag),
        .cycleStartFlag(cycleStartFlag), .pinCfgWrite(pinCfgWrite), .pinGpModeIn(pinGpModeIn),
        .pinGpOutIn(pinGpOutIn), .rxFifoEmptyPinOrGpout0(pin0), .cycleDonePinOrGpout1(pin1),
        .cycleStartPinOrGpout2(pin2));
    plk_phy_model plk_phy_model_inst (.sclk(sclk), .ctl(ctlIn), .data(dataIn),
        .lreq(linkRequest));
    // Host clock at 40 ns and an unrelated link clock at 30 ns.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        sclk = 1'b0;
        #7;
        forever #15 sclk = ~sclk;
    end
    // Compares one result and counts it.
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("compared %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // Cuts a hang short well after the tests should have ended.
    initial begin
        #2_000_000;
        err_count++;
        results();
    end
    // Pulses one strobe for a single cycle.
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        repeat (2) @(negedge clk);
    endtask : pulse
    initial begin
        {resetn, linkPowerUp, reqValid, cycleTimerEnable, cycleMaster, cycleSourceExt} = '0;
        {cycleDoneEvent, cycleDoneClear, cycleStartClear, pinCfgWrite, rxSpeed} = '0;
        {reqType, reqSpeed, reqAddr, reqData, pinGpModeIn, pinGpOutIn} = '0;
        extCycleClockIn = 1'b1;
        rxFifoEmptyFlag = 1'b1;
        void'($urandom(32'h2489));
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        chk(17'({pin2, pin1, pin0}), 17'h1);
        rxFifoEmptyFlag = 1'b0;
        linkPowerUp = 1'b1;
        @(posedge linkPowerIndicator);
        @(negedge clk);
        chk(17'(pin0), 17'h0);
        n = 0;
        while (linkPowerIndicator === 1'b1) begin
            n++;
            @(negedge clk);
        end
        chk(17'(n), 17'(POWER_DIV / 2));
        // Write, read and bus requests; shorter words are followed by zeros in the capture.
        for (int t = 0; t < 3; t++) begin
            reqAddr = 4'($urandom);
            reqData = 8'($urandom);
            reqSpeed = 3'($urandom);
            if (t == 0) begin
                reqType = REQ_WRITE;
                expWord = {1'b1, REQ_WRITE, reqAddr, reqData, 1'b0};
            end else if (t == 1) begin
                reqType = REQ_READ;
                expWord = {1'b1, REQ_READ, reqAddr, 1'b0, 8'h00};
            end else begin
                reqType = 3'($urandom_range(3));
                expWord = {1'b1, reqType, reqSpeed, 1'b0, 9'h000};
            end
            pulse(reqValid);
            for (n = 0; n < 300 && reqReady !== 1'b1; n++) @(negedge clk);
            repeat (10) @(negedge clk);
            chk(plk_phy_model_inst.reqWord, expWord);
        end
        // A grant makes the link drive idle for exactly one PHY clock.
        plk_phy_model_inst.grant();
        #1;
        chk(17'({ctlOe, dataOe, ctlOut, dataOut}), 17'hc00);
        hb = halfRateClk;
        @(posedge sclk);
        #1;
        chk(17'({ctlOe, dataOe, halfRateClk}), 17'({2'b00, ~hb}));
        @(negedge clk);
        cycleTimerEnable = 1'b1;
        for (int s = 0; s < 3; s++) begin
            rxSpeed = 2'(s);
            repeat (4) @(negedge clk);
            plk_phy_model_inst.sendPkt(2 << s, 24'($urandom));
            for (n = 0; n < 20 && pin2 !== 1'b1; n++) @(negedge clk);
            chk(17'({cycleStartFlag, pin2}), 17'h3);
            pulse(cycleStartClear);
            chk(17'({cycleStartFlag, pin2}), 17'h0);
        end
        pulse(cycleDoneEvent);
        chk(17'({cycleDoneFlag, pin1}), 17'h3);
        pulse(cycleDoneClear);
        chk(17'({cycleDoneFlag, pin1}), 17'h0);
        cycleSourceExt = 1'b1;
        repeat (1600) @(negedge clk);
        chk(17'(cycleClockOut), 17'h0);
        extCycleClockIn = 1'b0;
        #80;
        extCycleClockIn = 1'b1;
        for (n = 0; n < 10 && cycleStartFlag !== 1'b1; n++) @(negedge clk);
        chk(17'({cycleStartFlag, cycleClockOut}), 17'h3);
        // Own timer: measure one full period of the cycle clock output.
        cycleSourceExt = 1'b0;
        cycleMaster = 1'b1;
        @(posedge cycleClockOut);
        @(negedge clk);
        for (n = 0; n < 4000 && cycleClockOut === 1'b1; n++) @(negedge clk);
        chk(17'(n), 17'(CYCLE_OUT_HIGH));
        for (; n < 4000 && cycleClockOut === 1'b0; n++) @(negedge clk);
        chk(17'(n), 17'(CYCLE_CLKS));
        pinGpModeIn = 3'h7;
        pinGpOutIn = 3'($urandom);
        pulse(pinCfgWrite);
        chk(17'({pin2, pin1, pin0}), 17'(pinGpOutIn));
        results();
    end
endmodule : plk_top_tb_top
